/* File: src/nvmapc_top.sv */
// Nonvolatile memory access, protection and command logic with an AHB-Lite slave
`timescale 1ns/1ps
module nvmapc_top #(
	parameter int FLASH_BYTES = 65536,
	parameter int BOOT_PAGES = 4,
	parameter int CODE_PAGES = 8,
	parameter int ERASE_CYC = nvmapc_pkg::FL_ERASE_CYC,
	parameter logic [7:0] SIG_SEED = 8'h5A
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic [nvmapc_pkg::PTR_W-1:0] exec_addr,
	output logic fetch_block,
	input wire logic dbg_valid,
	input wire logic dbg_write,
	input wire logic [nvmapc_pkg::DA_W-1:0] dbg_addr,
	input wire logic [7:0] dbg_wdata,
	input wire logic dbg_locked,
	output logic dbg_ready,
	output logic [7:0] dbg_rdata,
	output logic [8*nvmapc_pkg::FUSE_BYTES-1:0] fuse_config,
	output logic fuse_loaded
);
	import nvmapc_pkg::*;

	localparam int FLASH_AW = $clog2(FLASH_BYTES);
	localparam int FP_W = FLASH_AW - PAGE_BITS;

	// ----------------------------------------------------------------
	// Elaboration check
	// ----------------------------------------------------------------
	if (FLASH_BYTES < WIN_BYTES || FLASH_BYTES > (WIN_BYTES << WIN_SEL_W) ||
		(FLASH_BYTES & (FLASH_BYTES - 1)) != 0 || ERASE_CYC < 1 ||
		BOOT_PAGES > FLASH_BYTES / PAGE_BYTES) begin : g_bad_param
		$error("nvmapc_top: unsupported parameter set");
	end

	typedef enum logic [1:0] {FL_IDLE, FL_PROG, FL_ERASE} nvmapc_fl_e;
	typedef enum logic {EE_IDLE, EE_BUSY} nvmapc_ee_e;

	logic [7:0] flash_mem [FLASH_BYTES];
	logic [7:0] ee_mem [EE_BYTES];
	logic [7:0] user_mem [USER_BYTES];
	logic [7:0] fuse_mem [FUSE_BYTES];

	logic ph_valid;
	logic ph_write;
	logic [DA_W-1:0] ph_daddr;
	logic [7:0] cmd;
	logic boot_rd_lock;
	logic code_wp;
	logic data_wp;
	logic boot_armed;
	logic [WIN_SEL_W-1:0] win_sel;
	logic [2:0] key_win;
	logic [PTR_W-1:0] ptr;
	nvmapc_fl_e fl_state;
	logic [31:0] fl_cnt;
	logic [FLASH_AW-1:0] fl_addr;
	logic [15:0] fl_data;
	logic fl_word;
	logic [FP_W-1:0] fl_pmask;
	nvmapc_ee_e ee_state;
	logic [31:0] ee_cnt;
	logic [EE_AW-1:0] ee_addr;
	logic [EE_AW-1:0] ee_mask;
	logic [7:0] ee_data;
	logic ee_erase;
	logic ee_prog;
	logic [FUSE_AW:0] load_idx;
	logic [31:0] rd_word;
	logic [7:0] dbg_byte;

	// ----------------------------------------------------------------
	// Helper functions
	// ----------------------------------------------------------------
	function automatic logic in_rng(input logic [15:0] a, input logic [15:0] base,
		input int size);
		return (32'(a) >= 32'(base)) && (32'(a) < 32'(base) + 32'(size));
	endfunction : in_rng

	// Section of a flash page from the section boundaries
	function automatic logic [1:0] section_of(input logic [FP_W-1:0] page);
		if (BOOT_PAGES == 0 || 32'(page) < 32'(BOOT_PAGES)) begin
			return SEC_BOOT;
		end
		if (CODE_PAGES == 0) begin
			return SEC_CODE;
		end
		if (CODE_PAGES > BOOT_PAGES && 32'(page) < 32'(CODE_PAGES)) begin
			return SEC_CODE;
		end
		return SEC_DATA;
	endfunction : section_of

	// Inter-section protection plus the sticky write locks
	function automatic logic may_write(input logic [1:0] tsec, input logic [1:0] xsec);
		if (tsec == SEC_CODE) begin
			return (xsec == SEC_BOOT) && !code_wp;
		end
		if (tsec == SEC_DATA) begin
			return (xsec != SEC_DATA) && !data_wp;
		end
		return 1'b0;
	endfunction : may_write

	// Low address bits ignored by a multi-unit erase command
	function automatic logic [31:0] unit_mask(input logic [7:0] c, input logic [7:0] first);
		return (32'h1 << (c - first)) - 32'h1;
	endfunction : unit_mask

	// ----------------------------------------------------------------
	// Decode of the transfer in its data phase
	// ----------------------------------------------------------------
	logic [FLASH_AW-1:0] win_addr;
	logic [FLASH_AW-1:0] ptr_addr;
	logic [FLASH_AW-1:0] fl_tgt;
	logic [1:0] exec_sec;
	logic r_cmd, r_ctrl, r_status, r_key, r_ptr, r_pdata;
	logic r_win, r_ee, r_user, r_sig, r_fuse, r_arr;
	logic fl_busy, ee_busy, nvm_busy, take, act, go, wr;
	logic fl_er_cmd, ee_er_cmd, fl_ok, fl_wr_req, fl_er_req, cmd_ok, whole_erase_command_go, eeprom_full_erase_go;
	logic ee_req, fl_done, ee_done, dbg_go, d_user, d_fuse, d_sig;

	assign win_addr = FLASH_AW'({win_sel, ph_daddr[WIN_BITS-1:0]});
	assign ptr_addr = ptr[FLASH_AW-1:0];
	assign exec_sec = section_of(exec_addr[FLASH_AW-1:PAGE_BITS]);
	assign r_cmd = ph_daddr == A_CMD;
	assign r_ctrl = ph_daddr == A_CTRL;
	assign r_status = ph_daddr == A_STATUS;
	assign r_key = ph_daddr == A_KEY;
	assign r_ptr = ph_daddr == A_PTR;
	assign r_pdata = ph_daddr == A_PDATA;
	assign r_win = in_rng(ph_daddr, A_FLASH, WIN_BYTES);
	assign r_ee = in_rng(ph_daddr, A_EE, EE_BYTES);
	assign r_user = in_rng(ph_daddr, A_USER, USER_BYTES);
	assign r_sig = in_rng(ph_daddr, A_SIG, SIG_BYTES);
	assign r_fuse = in_rng(ph_daddr, A_FUSE, FUSE_BYTES);
	assign r_arr = r_win | r_pdata | r_ee | r_user | r_sig | r_fuse;

	// Busy flags follow the operation state machines
	assign fl_busy = fl_state != FL_IDLE;
	assign ee_busy = ee_state != EE_IDLE;
	assign nvm_busy = fl_busy | ee_busy;
	assign take = hsel && htrans == HTRANS_NONSEQ && hready && hreadyout;
	assign act = ph_valid && !hreadyout;
	// Array accesses wait out a running operation instead of seeing half-written data
	assign go = act && !(r_arr && nvm_busy);
	assign wr = go && ph_write;

	assign fl_er_cmd = cmd >= CMD_FLPER && cmd <= CMD_FLMPER32;
	assign ee_er_cmd = cmd >= CMD_EEBER && cmd <= CMD_EEMBER32;
	// Word writes drop pointer bit 0
	assign fl_tgt = r_pdata ? {ptr_addr[FLASH_AW-1:1], 1'b0} : win_addr;
	assign fl_ok = may_write(section_of(fl_tgt[FLASH_AW-1:PAGE_BITS]), exec_sec);
	assign fl_wr_req = wr && (r_win || r_pdata) && fl_ok && cmd == CMD_FLASH_WRITE_MODE;
	assign fl_er_req = wr && (r_win || r_pdata) && fl_ok && fl_er_cmd;
	assign cmd_ok = wr && r_cmd && key_win != '0;
	assign whole_erase_command_go = cmd_ok && hwdata[7:0] == CMD_WHOLE_ERASE_COMMAND;
	assign eeprom_full_erase_go = cmd_ok && hwdata[7:0] == CMD_EEPROM_FULL_ERASE;
	assign ee_req = wr && r_ee && (cmd == CMD_EEWR || cmd == CMD_EEERWR || ee_er_cmd);
	assign fl_done = fl_busy && fl_cnt == '0;
	assign ee_done = ee_busy && ee_cnt == '0;

	// Debug port decode; it waits while an operation runs
	assign dbg_go = dbg_valid && !dbg_ready && !nvm_busy;
	assign d_user = in_rng(dbg_addr, A_USER, USER_BYTES);
	assign d_fuse = in_rng(dbg_addr, A_FUSE, FUSE_BYTES);
	assign d_sig = in_rng(dbg_addr, A_SIG, SIG_BYTES);

	// ----------------------------------------------------------------
	// Read data of the bus and of the debug port
	// ----------------------------------------------------------------
	// Read mux; boot bytes read as zero once the boot read lock is armed
	always_comb begin
		rd_word = '0;
		if (r_cmd) begin
			rd_word[7:0] = cmd;
		end else if (r_ctrl) begin
			rd_word[CB_BOOT_RD] = boot_rd_lock;
			rd_word[CB_CODE_WP] = code_wp;
			rd_word[CB_DATA_WP] = data_wp;
			rd_word[CB_WIN_LSB +: WIN_SEL_W] = win_sel;
		end else if (r_status) begin
			rd_word[ST_FLASH_BUSY_FLAG] = fl_busy;
			rd_word[ST_EEPROM_BUSY_FLAG] = ee_busy;
		end else if (r_ptr) begin
			rd_word[PTR_W-1:0] = ptr;
		end else if (r_pdata) begin
			if (!(boot_armed && section_of(ptr_addr[FLASH_AW-1:PAGE_BITS]) == SEC_BOOT)) begin
				rd_word[7:0] = flash_mem[ptr_addr];
			end
		end else if (r_win) begin
			if (!(boot_armed && section_of(win_addr[FLASH_AW-1:PAGE_BITS]) == SEC_BOOT)) begin
				rd_word[7:0] = flash_mem[win_addr];
			end
		end else if (r_ee) begin
			rd_word[7:0] = ee_mem[ph_daddr[EE_AW-1:0]];
		end else if (r_user) begin
			rd_word[7:0] = user_mem[ph_daddr[USER_AW-1:0]];
		end else if (r_sig) begin
			rd_word[7:0] = 8'(ph_daddr[SIG_AW-1:0]) ^ SIG_SEED;
		end else if (r_fuse) begin
			rd_word[7:0] = fuse_mem[ph_daddr[FUSE_AW-1:0]];
		end
	end

	// Debug reads; locked parts hide the user row
	always_comb begin
		dbg_byte = '0;
		if (d_user && !dbg_locked) begin
			dbg_byte = user_mem[dbg_addr[USER_AW-1:0]];
		end else if (d_fuse) begin
			dbg_byte = fuse_mem[dbg_addr[FUSE_AW-1:0]];
		end else if (d_sig) begin
			dbg_byte = 8'(dbg_addr[SIG_AW-1:0]) ^ SIG_SEED;
		end
	end

	// ----------------------------------------------------------------
	// AHB-Lite slave: one wait state at least, longer while stalled
	// ----------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ph_valid <= 1'b0;
			ph_write <= 1'b0;
			ph_daddr <= '0;
			hreadyout <= 1'b1;
			hrdata <= '0;
			hresp <= 1'b0;
		end else if (take) begin
			ph_valid <= 1'b1;
			ph_write <= hwrite;
			ph_daddr <= haddr[DA_LSB +: DA_W];
			hreadyout <= 1'b0;
		end else if (go) begin
			ph_valid <= 1'b0;
			hrdata <= ph_write ? '0 : rd_word;
			hreadyout <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Software registers
	// ----------------------------------------------------------------
	// Command and unlock window; any transfer inside the window uses up a slot
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cmd <= CMD_NONE;
			key_win <= '0;
		end else begin
			if (cmd_ok) begin
				cmd <= hwdata[7:0];
			end
			if (wr && r_key) begin
				key_win <= (hwdata[7:0] == KEY_VALUE) ? KEY_WINDOW : '0;
			end else if (go && key_win != '0) begin
				key_win <= key_win - 3'h1;
			end
		end
	end

	// Locks only set, never clear; boot lock only from boot code
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			boot_rd_lock <= 1'b0;
			code_wp <= 1'b0;
			data_wp <= 1'b0;
			win_sel <= '0;
			ptr <= '0;
		end else begin
			if (wr && r_ctrl) begin
				boot_rd_lock <= boot_rd_lock | (hwdata[CB_BOOT_RD] && exec_sec == SEC_BOOT);
				code_wp <= code_wp | hwdata[CB_CODE_WP];
				data_wp <= data_wp | hwdata[CB_DATA_WP];
				win_sel <= hwdata[CB_WIN_LSB +: WIN_SEL_W];
			end
			if (wr && r_ptr) begin
				ptr <= hwdata[PTR_W-1:0];
			end
		end
	end

	// Lock arms only after execution leaves boot, then fetches there are refused
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			boot_armed <= 1'b0;
			fetch_block <= 1'b0;
		end else begin
			boot_armed <= boot_armed | (boot_rd_lock && exec_sec != SEC_BOOT);
			fetch_block <= boot_armed && exec_sec == SEC_BOOT;
		end
	end

	// ----------------------------------------------------------------
	// Flash operation sequencer
	// ----------------------------------------------------------------
	// Address and data are latched at start so the pointer is free again
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			fl_state <= FL_IDLE;
			fl_cnt <= '0;
			fl_addr <= '0;
			fl_data <= '0;
			fl_word <= 1'b0;
			fl_pmask <= '0;
		end else begin
			unique case (fl_state)
				FL_IDLE: begin
					if (whole_erase_command_go) begin
						fl_state <= FL_ERASE;
						fl_cnt <= 32'(ERASE_CYC - 1);
						fl_pmask <= '1;
					end else if (fl_wr_req) begin
						fl_state <= FL_PROG;
						fl_cnt <= 32'(FL_WRITE_CYC - 1);
						fl_addr <= fl_tgt;
						fl_word <= r_pdata;
						fl_data <= r_pdata ? hwdata[15:0] : {ERASED_BYTE, hwdata[7:0]};
					end else if (fl_er_req) begin
						fl_state <= FL_ERASE;
						fl_cnt <= 32'(ERASE_CYC - 1);
						fl_addr <= fl_tgt;
						fl_pmask <= FP_W'(unit_mask(cmd, CMD_FLPER));
					end
				end
				FL_PROG, FL_ERASE: begin
					if (fl_cnt == '0) begin
						fl_state <= FL_IDLE;
					end else begin
						fl_cnt <= fl_cnt - 32'h1;
					end
				end
			endcase
		end
	end

	// Flash array: whole pages erased, programming only clears bits
	always_ff @(posedge hclk) begin
		if (fl_done && fl_state == FL_ERASE) begin
			for (int i = 0; i < FLASH_BYTES; i++) begin
				if ((FP_W'(i >> PAGE_BITS) | fl_pmask) ==
					(fl_addr[FLASH_AW-1:PAGE_BITS] | fl_pmask)) begin
					flash_mem[i] <= ERASED_BYTE;
				end
			end
		end else if (fl_done) begin
			flash_mem[fl_addr] <= flash_mem[fl_addr] & fl_data[7:0];
			if (fl_word) begin
				flash_mem[fl_addr | FLASH_AW'(1)] <= flash_mem[fl_addr | FLASH_AW'(1)] &
					fl_data[15:8];
			end
		end
	end

	// ----------------------------------------------------------------
	// EEPROM operation sequencer
	// ----------------------------------------------------------------
	// The core keeps running; only a further array access stalls on the busy flag
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ee_state <= EE_IDLE;
			ee_cnt <= '0;
			ee_addr <= '0;
			ee_mask <= '0;
			ee_data <= '0;
			ee_erase <= 1'b0;
			ee_prog <= 1'b0;
		end else begin
			unique case (ee_state)
				EE_IDLE: begin
					if (whole_erase_command_go || eeprom_full_erase_go) begin
						ee_state <= EE_BUSY;
						ee_cnt <= 32'(EE_OP_CYC - 1);
						ee_mask <= '1;
						ee_erase <= 1'b1;
						ee_prog <= 1'b0;
					end else if (ee_req) begin
						ee_state <= EE_BUSY;
						ee_cnt <= 32'(EE_OP_CYC - 1);
						ee_addr <= ph_daddr[EE_AW-1:0];
						ee_data <= hwdata[7:0];
						ee_erase <= cmd != CMD_EEWR;
						ee_prog <= cmd == CMD_EEWR || cmd == CMD_EEERWR;
						ee_mask <= ee_er_cmd ? EE_AW'(unit_mask(cmd, CMD_EEBER)) : '0;
					end
				end
				EE_BUSY: begin
					if (ee_cnt == '0) begin
						ee_state <= EE_IDLE;
					end else begin
						ee_cnt <= ee_cnt - 32'h1;
					end
				end
			endcase
		end
	end

	// EEPROM array: optional aligned block erase, then an optional single-byte program
	always_ff @(posedge hclk) begin
		if (ee_done) begin
			for (int i = 0; i < EE_BYTES; i++) begin
				if (ee_erase && (EE_AW'(i) | ee_mask) == (ee_addr | ee_mask)) begin
					ee_mem[i] <= ERASED_BYTE;
				end
			end
			if (ee_prog) begin
				ee_mem[ee_addr] <= (ee_erase ? ERASED_BYTE : ee_mem[ee_addr]) & ee_data;
			end
		end
	end

	// ----------------------------------------------------------------
	// User row and fuses (whole-device erase never touches them)
	// ----------------------------------------------------------------
	always_ff @(posedge hclk) begin
		if (wr && r_user && cmd == CMD_FLASH_WRITE_MODE) begin
			user_mem[ph_daddr[USER_AW-1:0]] <= user_mem[ph_daddr[USER_AW-1:0]] &
				hwdata[7:0];
		end
		if (wr && r_user && fl_er_cmd) begin
			for (int i = 0; i < USER_BYTES; i++) begin
				user_mem[i] <= ERASED_BYTE;
			end
		end
		// Locked debug writes act on the whole row
		if (dbg_go && dbg_write && d_user) begin
			if (dbg_locked) begin
				for (int i = 0; i < USER_BYTES; i++) begin
					user_mem[i] <= ERASED_BYTE;
				end
			end
			user_mem[dbg_addr[USER_AW-1:0]] <= dbg_wdata;
		end
	end

	// Only the debug port programs fuses; core writes fall through unused
	always_ff @(posedge hclk) begin
		if (dbg_go && dbg_write && d_fuse) begin
			fuse_mem[dbg_addr[FUSE_AW-1:0]] <= dbg_wdata;
		end
	end

	// Debug handshake, one ready pulse per request
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dbg_ready <= 1'b0;
			dbg_rdata <= '0;
		end else begin
			dbg_ready <= dbg_go;
			if (dbg_go) begin
				dbg_rdata <= dbg_write ? '0 : dbg_byte;
			end
		end
	end

	// Start-up copy of the fuses, one byte per cycle after reset release
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			load_idx <= '0;
			fuse_loaded <= 1'b0;
			fuse_config <= '0;
		end else if (!fuse_loaded) begin
			fuse_config[8*load_idx[FUSE_AW-1:0] +: 8] <= fuse_mem[load_idx[FUSE_AW-1:0]];
			load_idx <= load_idx + (FUSE_AW+1)'(1);
			fuse_loaded <= load_idx == (FUSE_AW+1)'(FUSE_BYTES - 1);
		end
	end
endmodule : nvmapc_top

/* File: include/nvmapc_pkg.sv */
// Constants, address map and command codes of the nonvolatile access controller
package nvmapc_pkg;
	// ----------------------------------------------------------------
	// Data-space map (word index on the bus = data-space address)
	// ----------------------------------------------------------------
	localparam int DA_W = 16;
	localparam int DA_LSB = 2;
	localparam logic [15:0] A_CMD = 16'h1000;
	localparam logic [15:0] A_CTRL = 16'h1001;
	localparam logic [15:0] A_STATUS = 16'h1002;
	localparam logic [15:0] A_KEY = 16'h1003;
	localparam logic [15:0] A_PTR = 16'h1004;
	localparam logic [15:0] A_PDATA = 16'h1005;
	localparam logic [15:0] A_FUSE = 16'h1050;
	localparam logic [15:0] A_USER = 16'h1080;
	localparam logic [15:0] A_SIG = 16'h1100;
	localparam logic [15:0] A_EE = 16'h1400;
	localparam logic [15:0] A_FLASH = 16'h8000;

	// ----------------------------------------------------------------
	// Array geometry
	// ----------------------------------------------------------------
	localparam int EE_BYTES = 512;
	localparam int EE_AW = 9;
	localparam int USER_BYTES = 32;
	localparam int USER_AW = 5;
	localparam int SIG_BYTES = 32;
	localparam int SIG_AW = 5;
	localparam int FUSE_BYTES = 4;
	localparam int FUSE_AW = 2;
	localparam int PAGE_BYTES = 512;
	localparam int PAGE_BITS = 9;
	localparam int WIN_BYTES = 32768;
	localparam int WIN_BITS = 15;
	localparam int PTR_W = 24;
	localparam logic [7:0] ERASED_BYTE = 8'hFF;

	// ----------------------------------------------------------------
	// Register fields
	// ----------------------------------------------------------------
	localparam int CB_BOOT_RD = 0;
	localparam int CB_CODE_WP = 1;
	localparam int CB_DATA_WP = 2;
	localparam int CB_WIN_LSB = 4;
	localparam int WIN_SEL_W = 2;
	localparam int ST_FLASH_BUSY_FLAG = 0;
	localparam int ST_EEPROM_BUSY_FLAG = 1;
	localparam logic [7:0] KEY_VALUE = 8'h9D;
	localparam logic [2:0] KEY_WINDOW = 3'h4;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

	// ----------------------------------------------------------------
	// Commands
	// ----------------------------------------------------------------
	localparam logic [7:0] CMD_NONE = 8'h00;
	localparam logic [7:0] CMD_NO_OPERATION_COMMAND = 8'h01;
	localparam logic [7:0] CMD_FLASH_WRITE_MODE = 8'h02;
	localparam logic [7:0] CMD_FLPER = 8'h08;
	localparam logic [7:0] CMD_FLMPER32 = 8'h0D;
	localparam logic [7:0] CMD_EEWR = 8'h12;
	localparam logic [7:0] CMD_EEERWR = 8'h13;
	localparam logic [7:0] CMD_EEBER = 8'h18;
	localparam logic [7:0] CMD_EEMBER32 = 8'h1D;
	localparam logic [7:0] CMD_WHOLE_ERASE_COMMAND = 8'h20;
	localparam logic [7:0] CMD_EEPROM_FULL_ERASE = 8'h30;

	// Flash sections
	localparam logic [1:0] SEC_BOOT = 2'h0;
	localparam logic [1:0] SEC_CODE = 2'h1;
	localparam logic [1:0] SEC_DATA = 2'h2;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_NS = 4;
	localparam int FL_WRITE_NS = 40;
	localparam int EE_OP_NS = 120;
	localparam int FL_ERASE_NS = 20000;
	localparam int FL_WRITE_CYC = (FL_WRITE_NS + CLK_NS - 1) / CLK_NS;
	localparam int EE_OP_CYC = (EE_OP_NS + CLK_NS - 1) / CLK_NS;
	localparam int FL_ERASE_CYC = (FL_ERASE_NS + CLK_NS - 1) / CLK_NS;
endpackage : nvmapc_pkg

/* File: dv/nvmapc_chk.sv */
// Port assertions of the nonvolatile access controller
`timescale 1ns/1ps
module nvmapc_chk #(
	parameter int BOOT_PAGES = 4
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [1:0] htrans,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [23:0] exec_addr,
	input wire logic fetch_block,
	input wire logic dbg_valid,
	input wire logic dbg_write,
	input wire logic dbg_ready,
	input wire logic [7:0] dbg_rdata,
	input wire logic fuse_loaded
);
	import nvmapc_pkg::*;
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// Steps of one bus transfer
	sequence s_taken;
		hsel && htrans == HTRANS_NONSEQ && hready && hreadyout;
	endsequence
	sequence s_done;
		##[1:300] hreadyout;
	endsequence
	a_resp_okay: assert property (hresp == 1'b0)
		else $error("error response seen");
	a_wait_taken: assert property (s_taken |=> !hreadyout)
		else $error("no wait after transfer");
	a_wait_bound: assert property ($fell(hreadyout) |-> s_done)
		else $error("bus wait never ends");
	a_dbg_pulse: assert property (dbg_ready |=> !dbg_ready)
		else $error("debug ready too long");
	a_dbg_answer: assert property (dbg_valid && !dbg_ready |-> ##[1:100] dbg_ready)
		else $error("debug request unanswered");
	a_dbg_wzero: assert property (dbg_ready && dbg_write |-> dbg_rdata == 8'h00)
		else $error("debug write data not zero");
	a_fuse_hold: assert property (fuse_loaded |=> fuse_loaded)
		else $error("fuse copy flag dropped");
	a_fetch_boot: assert property (fetch_block |-> $past(exec_addr) < BOOT_PAGES * PAGE_BYTES)
		else $error("fetch refused outside boot");
endmodule : nvmapc_chk

/* File: dv/nvmapc_dbg_model.sv */
// Debug port master model
`timescale 1ns/1ps
module nvmapc_dbg_model (
	input wire logic hclk,
	input wire logic dbg_ready,
	input wire logic [7:0] dbg_rdata,
	output logic dbg_valid,
	output logic dbg_write,
	output logic [15:0] dbg_addr,
	output logic [7:0] dbg_wdata
);
	// Idle port at time zero
	initial begin
		dbg_valid = 1'b0;
		dbg_write = 1'b0;
		dbg_addr = 16'h0000;
		dbg_wdata = 8'h00;
	end
	// One byte access; request held until ready, then lines scrambled
	task automatic xfer(input logic w, input logic [15:0] a, input logic [7:0] d,
		output logic [7:0] q);
		@(posedge hclk);
		dbg_valid <= 1'b1;
		dbg_write <= w;
		dbg_addr <= a;
		dbg_wdata <= d;
		do @(posedge hclk); while (dbg_ready !== 1'b1);
		q = dbg_rdata;
		dbg_valid <= 1'b0;
		dbg_addr <= ~a;
		dbg_wdata <= ~d;
	endtask : xfer
endmodule : nvmapc_dbg_model

/* File: dv/nvm_access_protect_cmd_tb.sv */
// Self-checking bench of the nonvolatile access controller
`timescale 1ns/1ps
module nvm_access_protect_cmd_tb;
	import nvmapc_pkg::*;
	logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, dbg_locked = 1'b0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd, fuse_config;
	logic [1:0] htrans = 2'h0;
	logic [23:0] exec_addr = 24'h0;
	logic hreadyout, hresp, fetch_block, dbg_ready, fuse_loaded, dbg_valid, dbg_write;
	logic [7:0] dbg_rdata, dbg_wdata, q;
	logic [15:0] dbg_addr;
	int mismatches = 0, samples_checked = 0, cyc = 0;
	always #2 hclk = ~hclk;
	nvmapc_top #(.ERASE_CYC(20)) i_dut(.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
		.hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .exec_addr,
		.fetch_block, .dbg_valid, .dbg_write, .dbg_addr, .dbg_wdata, .dbg_locked, .dbg_ready,
		.dbg_rdata, .fuse_config, .fuse_loaded);
	nvmapc_dbg_model i_dbg(.hclk, .dbg_ready, .dbg_rdata, .dbg_valid, .dbg_write,
		.dbg_addr, .dbg_wdata);
	task automatic chk(string n, logic [31:0] s, logic [31:0] e);
		samples_checked++;
		if (s !== e) begin
			mismatches++;
			$display("BAD %s exp %h saw %h", n, e, s);
		end
	endtask : chk
	// Single AHB word transfer; waits out every stall
	task automatic bus(logic w, logic [15:0] a, logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= HTRANS_NONSEQ;
		hwrite <= w;
		haddr <= {14'h0, a, 2'h0};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask : bus
	// Poll busy flags, unlock, then command
	task automatic cmd(logic [7:0] c);
		do bus(1'b0, A_STATUS, 0); while (rd[1:0] !== 2'h0);
		bus(1'b1, A_KEY, KEY_VALUE);
		bus(1'b1, A_CMD, c);
	endtask : cmd
	task automatic t_start;
		chk("fuse_loaded", fuse_loaded, 1);
		bus(1'b1, A_CMD, CMD_FLASH_WRITE_MODE);
		bus(1'b0, A_CMD, 0);
		chk("cmd_nokey", rd, 0);
		$display("t_start done");
	endtask : t_start
	task automatic t_flash;
		cmd(CMD_FLPER);
		bus(1'b1, 16'h9000, 0);
		bus(1'b0, A_STATUS, 0);
		chk("flash_busy", rd[0], 1);
		bus(1'b0, 16'h9000, 0);
		chk("erased", rd, 32'hFF);
		cmd(CMD_FLASH_WRITE_MODE);
		bus(1'b1, A_PTR, 32'h1001);
		bus(1'b1, A_PDATA, 32'hA55A);
		bus(1'b1, A_PTR, 32'h1003);
		bus(1'b0, 16'h9000, 0);
		chk("word_lo", rd, 32'h5A);
		bus(1'b0, A_PDATA, 0);
		chk("latched", rd, 32'hFF);
		bus(1'b1, A_PTR, 32'h1001);
		bus(1'b0, A_PDATA, 0);
		chk("word_hi", rd, 32'hA5);
		bus(1'b1, 16'h9002, 32'h3C);
		bus(1'b0, 16'h9002, 0);
		chk("byte_wr", rd, 32'h3C);
		bus(1'b1, A_CTRL, 32'h4);
		bus(1'b1, 16'h9004, 0);
		bus(1'b0, 16'h9004, 0);
		chk("data_lock", rd, 32'hFF);
		$display("t_flash done");
	endtask : t_flash
	task automatic t_rows;
		cmd(CMD_EEERWR);
		bus(1'b1, A_EE + 16'h3, 32'h3C);
		bus(1'b0, A_EE + 16'h3, 0);
		chk("ee_erwr", rd, 32'h3C);
		cmd(CMD_EEBER);
		bus(1'b1, A_EE + 16'h3, 0);
		bus(1'b0, A_EE + 16'h3, 0);
		chk("ee_erase", rd, 32'hFF);
		cmd(CMD_NO_OPERATION_COMMAND);
		bus(1'b1, A_SIG, 0);
		bus(1'b0, A_SIG, 0);
		chk("sig_ro", rd, 32'h5A);
		dbg_locked <= 1'b1;
		i_dbg.xfer(1'b0, A_USER, 8'h00, q);
		chk("user_locked", q, 0);
		i_dbg.xfer(1'b1, A_USER, 8'h12, q);
		bus(1'b0, A_USER + 16'h1, 0);
		chk("user_page", rd, 32'hFF);
		bus(1'b1, A_CTRL, 32'h1);
		exec_addr <= 24'h001000;
		bus(1'b0, 16'h8000, 0);
		chk("boot_lock", rd, 0);
		$display("t_rows done");
	endtask : t_rows
	// Back into boot, whole erase, then a fuse copy across a second reset
	task automatic t_erase;
		exec_addr <= 24'h000000;
		repeat (2) @(posedge hclk);
		chk("fetch_block", fetch_block, 1);
		cmd(CMD_WHOLE_ERASE_COMMAND);
		bus(1'b0, 16'h9002, 0);
		chk("whole_erase_command_flash", rd, 32'hFF);
		bus(1'b0, A_USER, 0);
		chk("user_kept", rd, 32'h12);
		i_dbg.xfer(1'b1, A_FUSE, 8'hC3, q);
		@(posedge hclk);
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		repeat (6) @(posedge hclk);
		chk("fuse_copy", fuse_config[7:0], 32'hC3);
		$display("t_erase done");
	endtask : t_erase
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : report_and_stop
	// Hang guard
	always @(posedge hclk) begin
		cyc++;
		if (cyc == 20000) begin
			mismatches++;
			report_and_stop;
		end
	end
	initial begin
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		repeat (6) @(posedge hclk);
		t_start;
		t_flash;
		t_rows;
		t_erase;
		report_and_stop;
	end
endmodule : nvm_access_protect_cmd_tb
bind nvmapc_top nvmapc_chk #(.BOOT_PAGES(BOOT_PAGES)) i_chk(.hclk, .hresetn, .hsel, .htrans,
	.hready, .hreadyout, .hresp, .exec_addr, .fetch_block, .dbg_valid, .dbg_write, .dbg_ready,
	.dbg_rdata, .fuse_loaded);
